// *** verilog/fsqm_regs.vh ***
`ifndef FSQM_REGS_VH
`define FSQM_REGS_VH
// instruction codes
`define FSQM_OP_FUNC_WR     8'h42
`define FSQM_OP_QEN         8'h35
`define FSQM_OP_QEX         8'hF5
`define FSQM_OP_SUS_A       8'h75
`define FSQM_OP_SUS_B       8'hB0
`define FSQM_OP_RSM_A       8'h7A
`define FSQM_OP_RSM_B       8'h30
`define FSQM_OP_WR_EN       8'h06
`define FSQM_OP_WR_DIS      8'h04
`define FSQM_OP_STAT_WR     8'h01
`define FSQM_OP_PP          8'h02
`define FSQM_OP_PPQ_A       8'h32
`define FSQM_OP_PPQ_B       8'h38
`define FSQM_OP_SER_A       8'hD7
`define FSQM_OP_SER_B       8'h20
`define FSQM_OP_BER32       8'h52
`define FSQM_OP_BER64       8'hD8
`define FSQM_OP_CER_A       8'hC7
`define FSQM_OP_CER_B       8'h60
// function register field positions
`define FSQM_FR_RSTDIS      0
`define FSQM_FR_PROG_SUS    2
`define FSQM_FR_ERASE_SUS   3
`define FSQM_FR_IRL_LO      4
// reset value of function register
`define FSQM_FR_RESET       8'h00
// timing, in ns and cycles of a 25 ns clock
`define FSQM_CLK_NS         25
`define FSQM_SUS_LAT_NS     100000
`define FSQM_SUS_LAT_CYC    ((`FSQM_SUS_LAT_NS + `FSQM_CLK_NS - 1) / `FSQM_CLK_NS)
// operation kinds
`define FSQM_OPK_NONE       2'd0
`define FSQM_OPK_PROG       2'd1
`define FSQM_OPK_ERASE      2'd2
`define FSQM_OPK_CHIP       2'd3
`endif

// *** verilog/fsqm_sync.v ***
`timescale 1ns/1ps
// two-flop synchroniser for a bundle of level inputs
module fsqm_sync #(
    parameter W = 1
) (
    // clock and reset
    input  wire         mclk_in,
    input  wire         rst_b_in,
    input  wire         ce_in,
    // data
    input  wire [W-1:0] d_in,
    output wire [W-1:0] q_out
);
    reg [W-1:0] meta_ff;
    reg [W-1:0] sync_ff;

    // first stage feeds only the second
    always @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            meta_ff <= {W{1'b0}};
            sync_ff <= {W{1'b0}};
        end else if (ce_in) begin
            meta_ff <= d_in;
            sync_ff <= meta_ff;
        end
    end

    assign q_out = sync_ff;
endmodule // fsqm_sync

// *** verilog/fsqm_ctrl.v ***
`timescale 1ns/1ps
`include "fsqm_regs.vh"
module fsqm_ctrl #(
    parameter SUS_LAT_CYC = `FSQM_SUS_LAT_CYC
) (
    // clock, reset, enable
    input  wire       mclk_in,
    input  wire       rst_b_in,
    input  wire       ce_in,
    // serial link pins
    input  wire       sck_in,
    input  wire       cs_b_in,
    input  wire [3:0] dq_in,
    // array engine
    input  wire [1:0] op_start_kind_in,
    input  wire       op_start_in,
    input  wire       op_done_in,
    output reg        engine_pause_ff_out,
    output reg        engine_resume_out,
    // decoded instruction
    output reg  [7:0] cmd_code_out,
    output reg        cmd_valid_out,
    output reg        cmd_refused_out,
    // status
    output wire [7:0] func_reg_out,
    output wire       quad_command_mode_out,
    output wire       write_enable_latch_out,
    output wire       write_in_progress_out,
    output wire       suspend_busy_out,
    output wire       reset_pin_disable_out,
    output wire [3:0] info_row_lock_bits_out
);
    // synchronised pins
    wire [5:0] pin_s;
    fsqm_sync #(.W(6)) u_sync (
        .mclk_in  (mclk_in),
        .rst_b_in (rst_b_in),
        .ce_in    (ce_in),
        .d_in     ({sck_in, cs_b_in, dq_in}),
        .q_out    (pin_s)
    );
    wire       sck_s  = pin_s[5];
    wire       cs_b_s = pin_s[4];
    wire [3:0] dq_s   = pin_s[3:0];

    reg        sck_d_ff;
    reg        cs_d_ff;
    reg [15:0] shift_ff;
    reg [4:0]  nclk_ff;
    reg        quad_ff;
    reg        wlat_ff;
    reg        rst_dis_ff;
    reg [3:0]  irl_ff;
    reg        prog_sus_ff;
    reg        erase_sus_ff;
    reg [1:0]  op_kind_ff;
    reg        busy_ff;
    reg [16:0] lat_cnt_ff;

    wire sck_rise = sck_s & ~sck_d_ff;
    wire cs_fall  = ~cs_b_s & cs_d_ff;
    wire cs_rise  = cs_b_s & ~cs_d_ff;

    // code classification helpers
    function is_sus;
        input [7:0] c;
        is_sus = (c == `FSQM_OP_SUS_A) || (c == `FSQM_OP_SUS_B);
    endfunction
    function is_rsm;
        input [7:0] c;
        is_rsm = (c == `FSQM_OP_RSM_A) || (c == `FSQM_OP_RSM_B);
    endfunction
    function is_prog;
        input [7:0] c;
        is_prog = (c == `FSQM_OP_PP) || (c == `FSQM_OP_PPQ_A) || (c == `FSQM_OP_PPQ_B);
    endfunction
    function is_erase;
        input [7:0] c;
        is_erase = (c == `FSQM_OP_SER_A) || (c == `FSQM_OP_SER_B) ||
                   (c == `FSQM_OP_BER32) || (c == `FSQM_OP_BER64) ||
                   (c == `FSQM_OP_CER_A) || (c == `FSQM_OP_CER_B);
    endfunction
    // accepted in either kind of suspend
    function ok_any;
        input [7:0] c;
        begin
            case (c)
                8'h03, 8'h0B, 8'hBB, 8'h3B, 8'hEB, 8'h6B, 8'h0D, 8'hBD, 8'hED,
                8'h06, 8'h04, 8'h05, 8'h48, 8'h61, 8'h81, 8'hAB, 8'h9F, 8'h90,
                8'hAF, 8'h4B, 8'h5A, 8'h82: ok_any = 1'b1;
                8'h7A, 8'h30, 8'hC0, 8'h63, 8'h83, 8'hFC, 8'hFA, 8'hE7, 8'hA7,
                8'h2B: ok_any = 1'b1;
                default: ok_any = 1'b0;
            endcase
        end
    endfunction
    // extra codes during erase suspend
    function ok_erase_only;
        input [7:0] c;
        begin
            case (c)
                8'h24, 8'h26, 8'h75, 8'hB0, 8'h02, 8'h32, 8'h38,
                8'hFB: ok_erase_only = 1'b1;
                default: ok_erase_only = 1'b0;
            endcase
        end
    endfunction

    // frame length: a whole code, or a code followed by one data byte
    wire       full      = quad_ff ? (nclk_ff >= 5'd2) : (nclk_ff >= 5'd8);
    wire       with_data = quad_ff ? (nclk_ff >= 5'd4) : (nclk_ff >= 5'd16);

    // the first byte shifted in is the code, the second the data
    wire [7:0] code    = with_data ? shift_ff[15:8] : shift_ff[7:0];
    wire [7:0] data    = shift_ff[7:0];

    // decode of the frame that just ended
    wire       susp    = prog_sus_ff | erase_sus_ff;
    wire       allowed = ~susp ? 1'b1 :
                         (ok_any(code) | (erase_sus_ff & ok_erase_only(code)));
    wire       blocked = (erase_sus_ff & (is_erase(code) | code == `FSQM_OP_STAT_WR)) |
                         (prog_sus_ff & (is_prog(code) | code == `FSQM_OP_STAT_WR));
    wire       take    = cs_rise & full & ~suspend_busy_out & allowed & ~blocked;
    wire       op_run  = busy_ff & ~susp;
    wire       op_end  = op_done_in & op_run;
    // function write needs the latch, an idle engine and a data byte
    wire       func_wr = take & (code == `FSQM_OP_FUNC_WR) & with_data &
                         wlat_ff & ~busy_ff;
    wire       do_sus  = take & is_sus(code) & op_run &
                         (op_kind_ff != `FSQM_OPK_CHIP);
    wire       do_rsm  = take & is_rsm(code) & susp;

    // edge detection on the synchronised pins
    always @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            sck_d_ff <= 1'b0;
            cs_d_ff  <= 1'b1;
        end else if (ce_in) begin
            sck_d_ff <= sck_s;
            cs_d_ff  <= cs_b_s;
        end
    end

    // clock counting and instruction shifting
    always @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            shift_ff <= 16'h0000;
            nclk_ff  <= 5'h00;
        end else if (ce_in) begin
            if (cs_fall) begin
                nclk_ff <= 5'h00;
            end else if (!cs_b_s && sck_rise && nclk_ff != 5'h1F) begin
                nclk_ff <= nclk_ff + 5'h01;
                // code then data byte; later address bits are not kept
                if (quad_ff && nclk_ff < 5'd4) begin
                    shift_ff <= {shift_ff[11:0], dq_s};
                end else if (!quad_ff && nclk_ff < 5'd16) begin
                    shift_ff <= {shift_ff[14:0], dq_s[0]};
                end
            end
        end
    end

    // suspend-to-ready latency counter
    always @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            lat_cnt_ff <= 17'h0_0000;
        end else if (ce_in) begin
            if (do_sus) begin
                lat_cnt_ff <= SUS_LAT_CYC[16:0];
            end else if (lat_cnt_ff != 17'h0_0000) begin
                lat_cnt_ff <= lat_cnt_ff - 17'h0_0001;
            end
        end
    end

    // engine started or finished its work
    always @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            busy_ff    <= 1'b0;
            op_kind_ff <= `FSQM_OPK_NONE;
        end else if (ce_in) begin
            if (op_start_in && !busy_ff) begin
                busy_ff    <= 1'b1;
                op_kind_ff <= op_start_kind_in;
            end else if (op_end) begin
                // completion is ignored while suspended
                busy_ff    <= 1'b0;
                op_kind_ff <= `FSQM_OPK_NONE;
            end
        end
    end

    // command mode changes only when a frame is closed
    always @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            quad_ff <= 1'b0;
        end else if (ce_in && take) begin
            if (code == `FSQM_OP_QEN) begin
                quad_ff <= 1'b1;
            end else if (code == `FSQM_OP_QEX && quad_ff) begin
                // exit is a quad-only code
                quad_ff <= 1'b0;
            end
        end
    end

    // write-enable latch: set by command, cleared by use or suspend
    always @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            wlat_ff <= 1'b0;
        end else if (ce_in) begin
            if (take && code == `FSQM_OP_WR_EN) begin
                wlat_ff <= 1'b1;
            end else if (take && code == `FSQM_OP_WR_DIS) begin
                wlat_ff <= 1'b0;
            end else if (do_sus) begin
                wlat_ff <= 1'b0;
            end else if (func_wr || op_end) begin
                wlat_ff <= 1'b0;
            end
        end
    end

    // one-time bits: only ever or-ed with the data byte
    always @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rst_dis_ff <= 1'b0;
            irl_ff     <= 4'h0;
        end else if (ce_in && func_wr) begin
            rst_dis_ff <= rst_dis_ff | data[`FSQM_FR_RSTDIS];
            irl_ff     <= irl_ff | data[`FSQM_FR_IRL_LO +: 4];
        end
    end

    // suspend status flags, one per kind of paused work
    always @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            prog_sus_ff  <= 1'b0;
            erase_sus_ff <= 1'b0;
        end else if (ce_in) begin
            // a paused program shows in the program flag
            if (do_sus && op_kind_ff == `FSQM_OPK_PROG) begin
                prog_sus_ff <= 1'b1;
            end else if (do_rsm) begin
                prog_sus_ff <= 1'b0;
            end
            // sector and block erases share the erase flag
            if (do_sus && op_kind_ff != `FSQM_OPK_PROG) begin
                erase_sus_ff <= 1'b1;
            end else if (do_rsm) begin
                erase_sus_ff <= 1'b0;
            end
        end
    end

    // engine pause level and resume strobe
    always @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            engine_pause_ff_out <= 1'b0;
            engine_resume_out   <= 1'b0;
        end else if (ce_in) begin
            engine_resume_out <= do_rsm;
            if (do_sus) begin
                engine_pause_ff_out <= 1'b1;
            end else if (do_rsm) begin
                engine_pause_ff_out <= 1'b0;
            end
        end
    end

    // decoded command outputs, one pulse per closed frame that holds at least a whole code
    always @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cmd_code_out    <= 8'h00;
            cmd_valid_out   <= 1'b0;
            cmd_refused_out <= 1'b0;
        end else if (ce_in) begin
            cmd_valid_out   <= take;
            cmd_refused_out <= cs_rise & full & ~take;
            if (cs_rise && full) begin
                cmd_code_out <= code;
            end
        end
    end

    // status outputs
    assign suspend_busy_out       = (lat_cnt_ff != 17'h0_0000);
    assign write_in_progress_out  = op_run | suspend_busy_out;
    assign quad_command_mode_out  = quad_ff;
    assign write_enable_latch_out = wlat_ff;
    assign reset_pin_disable_out  = rst_dis_ff;
    assign info_row_lock_bits_out = irl_ff;
    // locks on top, erase and program flags in bits 3 and 2
    assign func_reg_out = {irl_ff, erase_sus_ff, prog_sus_ff, 1'b0, rst_dis_ff};
endmodule // fsqm_ctrl

// *** dv/fsqm_ctrl_monitor.sv ***
`timescale 1ns/1ps
module fsqm_ctrl_monitor #(
    parameter SUS_LAT_CYC = 4000
) (
    input wire       mclk_in,
    input wire       rst_b_in,
    input wire       cmd_valid_out,
    input wire       cmd_refused_out,
    input wire [7:0] cmd_code_out,
    input wire [7:0] func_reg_out,
    input wire       quad_command_mode_out,
    input wire       write_enable_latch_out,
    input wire       write_in_progress_out,
    input wire       suspend_busy_out,
    input wire       engine_pause_ff_out
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rst_b_in);
    // length of the open latency window
    reg [15:0] busy_cnt_ff;
    always @(posedge mclk_in or negedge rst_b_in)
        if (!rst_b_in) busy_cnt_ff <= 16'h0000;
        else busy_cnt_ff <= suspend_busy_out ? busy_cnt_ff + 16'h0001 : 16'h0000;
    sequence s_sus; $rose(|func_reg_out[3:2]); endsequence
    property p_otp; ($past(func_reg_out) & 8'hF1 & ~func_reg_out) == 8'h00; endproperty
    property p_wel; s_sus |-> !write_enable_latch_out && engine_pause_ff_out; endproperty
    property p_lat; s_sus |-> suspend_busy_out [*8]; endproperty
    property p_len; $fell(suspend_busy_out) |-> busy_cnt_ff == SUS_LAT_CYC; endproperty
    property p_gate; $past(suspend_busy_out) && suspend_busy_out |-> !cmd_valid_out; endproperty
    property p_flag; engine_pause_ff_out == (|func_reg_out[3:2]); endproperty
    property p_rsm; $fell(engine_pause_ff_out) |-> write_in_progress_out; endproperty
    property p_wip; engine_pause_ff_out |-> write_in_progress_out == suspend_busy_out; endproperty
    property p_quad; $changed(quad_command_mode_out) |-> cmd_valid_out &&
        cmd_code_out == (quad_command_mode_out ? 8'h35 : 8'hF5); endproperty
    property p_pulse; cmd_valid_out |=> !cmd_valid_out && !cmd_refused_out; endproperty
    a_otp: assert property (p_otp) else $error("one-time bit cleared");
    a_wel: assert property (p_wel) else $error("latch kept on suspend");
    a_lat: assert property (p_lat) else $error("latency too short");
    a_len: assert property (p_len) else $error("latency length wrong");
    a_gate: assert property (p_gate) else $error("command taken while busy");
    a_flag: assert property (p_flag) else $error("flags and pause differ");
    a_rsm: assert property (p_rsm) else $error("resume did not restart");
    a_wip: assert property (p_wip) else $error("progress bit wrong");
    a_quad: assert property (p_quad) else $error("mode changed wrongly");
    a_pulse: assert property (p_pulse) else $error("answer not one pulse");
endmodule // fsqm_ctrl_monitor
bind fsqm_ctrl fsqm_ctrl_monitor #(.SUS_LAT_CYC(SUS_LAT_CYC)) mon_u (
    .mclk_in(mclk_in), .rst_b_in(rst_b_in), .cmd_valid_out(cmd_valid_out),
    .cmd_refused_out(cmd_refused_out), .cmd_code_out(cmd_code_out),
    .func_reg_out(func_reg_out), .quad_command_mode_out(quad_command_mode_out),
    .write_enable_latch_out(write_enable_latch_out),
    .write_in_progress_out(write_in_progress_out), .suspend_busy_out(suspend_busy_out),
    .engine_pause_ff_out(engine_pause_ff_out));

// *** dv/fsqm_host_model.sv ***
`timescale 1ns/1ps
module fsqm_host_model (
    // clock
    input  wire       mclk_in,
    // link pins
    output reg        sck_out,
    output reg        cs_b_out,
    output reg  [3:0] dq_out
);
    // idle link: clock low, deselected
    initial begin
        sck_out = 1'b0;
        cs_b_out = 1'b1;
        dq_out = 4'h5;
    end
    // one framed instruction, code then optional data byte
    task xfer(input [7:0] c, input [7:0] d, input hd, input q);
        reg [15:0] v;
        integer i;
        begin
            v = {c, d};
            repeat (4) @(posedge mclk_in);
            cs_b_out <= 1'b0;
            for (i = 0; i < (q ? (hd ? 4 : 2) : (hd ? 16 : 8)); i = i + 1) begin
                @(posedge mclk_in);
                dq_out <= q ? v[15-4*i -: 4] : {~dq_out[3:1], v[15-i]};
                repeat (3) @(posedge mclk_in);
                sck_out <= 1'b1;
                repeat (4) @(posedge mclk_in);
                sck_out <= 1'b0;
            end
            repeat (4) @(posedge mclk_in);
            cs_b_out <= 1'b1;
            dq_out <= ~dq_out; // released lines lose the last value
        end
    endtask
endmodule // fsqm_host_model

// *** dv/flash_suspend_quad_mode_control_tb.sv ***
`timescale 1ns/1ps
module flash_suspend_quad_mode_control_tb;
    localparam [95:0] TAB = 96'h0B24_02D8_0120_FC48_0324_0102;
    reg        mclk_in, rst_b_in, ce_in, start, done;
    reg  [1:0] kind;
    wire       sck, cs_b, vld, rej, quad, wlat, write_in_progress, busy, pause, resm, rdis;
    wire [3:0] dq, irl;
    wire [7:0] code, fr;
    integer    error_cnt, n_tests, k, j;
    fsqm_host_model host_u (.mclk_in(mclk_in), .sck_out(sck), .cs_b_out(cs_b), .dq_out(dq));
    fsqm_ctrl #(.SUS_LAT_CYC(200)) dut_u (.mclk_in(mclk_in), .rst_b_in(rst_b_in),
        .ce_in(ce_in), .sck_in(sck), .cs_b_in(cs_b), .dq_in(dq), .op_start_kind_in(kind),
        .op_start_in(start), .op_done_in(done), .engine_pause_ff_out(pause),
        .engine_resume_out(resm), .cmd_code_out(code), .cmd_valid_out(vld),
        .cmd_refused_out(rej), .func_reg_out(fr), .quad_command_mode_out(quad),
        .write_enable_latch_out(wlat), .write_in_progress_out(write_in_progress), .suspend_busy_out(busy),
        .reset_pin_disable_out(rdis), .info_row_lock_bits_out(irl));
    // 40 MHz clock
    initial begin
        mclk_in = 1'b0;
        forever #12.5 mclk_in = ~mclk_in;
    end
    // compare and count
    task chk(input [7:0] seen, input [7:0] exp);
        begin
            n_tests = n_tests + 1;
            if (seen !== exp) begin
                error_cnt = error_cnt + 1;
                $display("CHECK FAILED %0t: saw %h want %h", $time, seen, exp);
            end
        end
    endtask
    // verdict and end of run
    task finish_test;
        if (error_cnt == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // send one instruction and check accept or refuse
    task cmd(input [7:0] c, input [7:0] d, input hd, input ok);
        integer t;
        begin
            host_u.xfer(c, d, hd, quad);
            t = 0;
            while (vld !== 1'b1 && rej !== 1'b1 && t < 40) begin
                @(posedge mclk_in);
                #1;
                t = t + 1;
            end
            if (t == 40) begin
                error_cnt = error_cnt + 1;
                finish_test;
            end
            chk({7'h00, vld}, {7'h00, ok});
        end
    endtask
    // engine start or completion strobe
    task eng(input [1:0] kd, input s, input dn);
        begin
            @(posedge mclk_in);
            kind <= kd;
            start <= s;
            done <= dn;
            @(posedge mclk_in);
            start <= 1'b0;
            done <= 1'b0;
            #1;
        end
    endtask
    // main sequence
    initial begin
        error_cnt = 0;
        n_tests = 0;
        rst_b_in = 1'b0;
        ce_in = 1'b1;
        kind = 2'b00;
        start = 1'b0;
        done = 1'b0;
        repeat (16) @(posedge mclk_in);
        rst_b_in <= 1'b1;
        repeat (4) @(posedge mclk_in);
        cmd(8'h06, 8'h00, 1'b0, 1'b1);
        chk({7'h00, wlat}, 8'h01);
        cmd(8'h42, 8'h11, 1'b1, 1'b1);
        chk(fr, 8'h11);
        chk({3'h0, rdis, irl}, 8'h11);
        chk({7'h00, wlat}, 8'h00);
        cmd(8'h06, 8'h00, 1'b0, 1'b1);
        cmd(8'h42, 8'hC0, 1'b1, 1'b1);
        chk(fr, 8'hD1);
        chk({3'h0, rdis, irl}, 8'h1D);
        cmd(8'h35, 8'h00, 1'b0, 1'b1);
        chk({7'h00, quad}, 8'h01);
        // fresh operation each pass, never a quick re-suspend
        for (k = 0; k < 8; k = k + 1) begin
            if (k == 4) begin
                cmd(8'hF5, 8'h00, 1'b0, 1'b1);
                chk({7'h00, quad}, 8'h00);
            end
            eng({k[1], ~k[1]}, 1'b1, 1'b0);
            chk({7'h00, write_in_progress}, 8'h01);
            cmd(8'h06, 8'h00, 1'b0, 1'b1);
            cmd(k[0] ? 8'hB0 : 8'h75, 8'h00, 1'b0, 1'b1);
            chk(fr, k[1] ? 8'hD9 : 8'hD5);
            chk({5'h00, pause, wlat, busy}, 8'h05);
            cmd(8'h03, 8'h00, 1'b0, 1'b0);
            j = 0;
            while (busy !== 1'b0 && j < 300) begin
                @(posedge mclk_in);
                #1;
                j = j + 1;
            end
            chk({6'h00, busy, write_in_progress}, 8'h00);
            for (j = 0; j < 6; j = j + 1)
                cmd(TAB[8*(6*k[1]+j) +: 8], 8'h00, 1'b0, j > 2);
            chk(fr, k[1] ? 8'hD9 : 8'hD5);
            cmd(k[0] ? 8'h30 : 8'h7A, 8'h00, 1'b0, 1'b1);
            chk({fr[7:1], write_in_progress}, 8'hD1);
            chk({6'h00, resm, pause}, 8'h02);
            eng({k[1], ~k[1]}, 1'b0, 1'b1);
            chk({7'h00, write_in_progress}, 8'h00);
        end
        eng(2'b11, 1'b1, 1'b0);
        cmd(8'h75, 8'h00, 1'b0, 1'b1);
        chk({fr[7:1], write_in_progress}, 8'hD1);
        eng(2'b11, 1'b0, 1'b1);
        finish_test;
    end
endmodule // flash_suspend_quad_mode_control_tb
